// file: bench/asb_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module asb_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch side
  input wire asb_pkg::asb_fetch_t fetch,
  input wire logic [31:0] stop,
  output logic fetchValid,
  output logic [15:0] fetchData,
  // Data side
  input wire asb_pkg::asb_mem_req_t mem,
  input wire logic slow,
  output logic memValid,
  output logic [31:0] memRdata
);
  import asb_pkg::*;
  logic [15:0] prog [128];
  logic [7:0] dm [256];
  logic [1:0] cnt;
  logic [31:0] rd;
  logic [31:0] last;
  wire logic [7:0] a = mem.addr[7:0];
  // The core parks at the stop address, so the bench can step a program.
  assign fetchValid = fetch.req && fetch.addr != stop;
  assign fetchData = fetchValid ? prog[fetch.addr[7:1]] : ~prog[fetch.addr[7:1]];
  assign memValid = mem.req && (!slow || cnt == 2'h2);
  assign rd = mem.size == SIZE_HALF ? {16'h0, dm[a + 8'h1], dm[a]} : {24'h0, dm[a]};
  // Outside a completion the data lines show the inverse of the last read.
  assign memRdata = memValid ? rd : ~last;
  always @(posedge clk) begin
    cnt <= (!rst_n || memValid || !mem.req) ? 2'h0 : cnt + 2'h1;
    if (!rst_n) begin
      last <= 32'h0;
    end else if (memValid) begin
      last <= rd;
      if (mem.write) begin
        dm[a] <= mem.wdata[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_cpu_alu_shift_branch_ops.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_alu_shift_branch_ops;
  import asb_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic ce = 1;
  logic regWrEn = 0;
  logic slow = 0;
  logic [3:0] regWrIdx = 4'h0;
  logic [3:0] regRdIdx = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic [31:0] globalBase = 32'h20;
  logic [31:0] stop = 32'h0;
  asb_fetch_t fetch;
  asb_mem_req_t mem;
  logic fetchValid, memValid, tFlag;
  logic [15:0] fetchData;
  logic [31:0] memRdata, regRdData, pcValue, procRetValue;
  logic [63:0] accValue;
  int num_errors = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  asb_core dut_u (.clk, .rst_n, .ce, .fetch, .fetchValid, .fetchData, .mem, .memValid,
    .memRdata, .regWrEn, .regWrIdx, .regWrData, .regRdIdx, .regRdData, .globalBase,
    .tFlag, .pcValue, .accValue, .procRetValue);
  asb_mem_model mdl_u (.clk, .rst_n, .fetch, .stop, .fetchValid, .fetchData, .mem,
    .slow, .memValid, .memRdata);
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rst();
    @(posedge clk);
    rst_n <= 1'b0;
    stop <= 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wr(logic [3:0] i, logic [31:0] v);
    @(posedge clk);
    regWrEn <= 1'b1;
    regWrIdx <= i;
    regWrData <= v;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(logic [3:0] i, output logic [31:0] v);
    @(posedge clk);
    regRdIdx <= i;
    @(negedge clk);
    v = regRdData;
  endtask
  // Releases the core up to address s and counts edges until it fetches there.
  task automatic go(logic [31:0] s, int c);
    int n;
    n = 0;
    @(posedge clk);
    stop <= s;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(fetch.req === 1'b1 && fetch.addr === s) && n < 100);
    if (c > 0) chk("cycles", c, n);
  endtask
  // A leading test of register three, still zero after reset, sets the flag when t is 1.
  task automatic alu(logic [15:0] op, logic [31:0] a, b, logic t, logic [31:0] e, logic et);
    logic [31:0] v;
    rst();
    wr(4'h0, a);
    wr(4'h1, a);
    wr(4'h2, b);
    mdl_u.prog[0] = t ? 16'h2338 : 16'h0009;
    mdl_u.prog[1] = op;
    go(32'h4, 4);
    rd(op[15:12] == 4'hc ? 4'h0 : 4'h1, v);
    chk("result", e, v);
    chk("flag", et, tFlag);
    $display("test op %h done", op);
  endtask
  task automatic mt(logic [15:0] op, logic t, s, logic [7:0] loc, d, e, logic et, int c);
    rst();
    slow <= s;
    wr(4'h0, 32'h10);
    wr(4'h1, 32'h10);
    mdl_u.dm[loc] = d;
    mdl_u.prog[0] = t ? 16'h2338 : 16'h0009;
    mdl_u.prog[1] = op;
    go(32'h4, c);
    chk("byte", e, mdl_u.dm[loc]);
    chk("flag", et, tFlag);
    $display("test memory op %h done", op);
  endtask
  task automatic t_mul();
    logic [31:0] v;
    rst();
    slow <= 1'b0;
    wr(4'h1, 32'h18000);
    wr(4'h2, 32'h2);
    mdl_u.prog[0] = 16'h212f;
    mdl_u.prog[1] = 16'h212e;
    mdl_u.prog[2] = 16'h412f;
    go(32'h2, 2);
    chk("acc", 64'hffff0000, accValue);
    // With the enable low the core must neither fetch nor step, though the stop no longer holds address 2 back.
    @(posedge clk);
    ce <= 1'b0;
    stop <= 32'h4;
    repeat (3) @(posedge clk);
    chk("frozen pc", 32'h2, pcValue);
    chk("frozen fetch", 0, fetch.req);
    ce <= 1'b1;
    stop <= 32'h2;
    go(32'h4, 2);
    chk("acc", 64'h10000, accValue);
    wr(4'h1, 32'h10);
    wr(4'h2, 32'h20);
    mdl_u.dm[16] = 8'hfe;
    mdl_u.dm[17] = 8'hff;
    mdl_u.dm[32] = 8'h03;
    mdl_u.dm[33] = 8'h00;
    go(32'h6, 4);
    chk("acc", 64'hfffa, accValue);
    rd(4'h1, v);
    chk("pointer", 32'h12, v);
    rd(4'h2, v);
    chk("pointer", 32'h22, v);
    $display("test multiply done");
  endtask
  task automatic t_br();
    logic [31:0] v;
    rst();
    wr(4'h4, 32'h28);
    wr(4'h5, 32'h30);
    // Every skipped slot overwrites register one, so a wrong path shows there.
    for (int i = 0; i < 32; i++) mdl_u.prog[i] = 16'h6127;
    mdl_u.prog[0] = 16'h8b02;
    mdl_u.prog[4] = 16'h8902;
    mdl_u.prog[5] = 16'ha003;
    mdl_u.prog[6] = 16'h2338;
    mdl_u.prog[10] = 16'hb004;
    mdl_u.prog[11] = 16'h0009;
    mdl_u.prog[16] = 16'h442b;
    mdl_u.prog[17] = 16'h0009;
    mdl_u.prog[20] = 16'h450b;
    mdl_u.prog[21] = 16'h0009;
    mdl_u.prog[22] = 16'h8902;
    mdl_u.prog[24] = 16'h000b;
    mdl_u.prog[25] = 16'h0009;
    mdl_u.prog[26] = 16'h8b02;
    go(32'h8, 4);
    go(32'ha, 2);
    go(32'h14, 5);
    chk("flag", 1, tFlag);
    go(32'h20, 5);
    chk("return", 32'h18, procRetValue);
    go(32'h28, 5);
    go(32'h30, 5);
    chk("return", 32'h2c, procRetValue);
    go(32'h2c, 5);
    go(32'h34, 4);
    go(32'h36, 2);
    chk("pc", 32'h36, pcValue);
    rd(4'h1, v);
    chk("skipped", 32'h0, v);
    $display("test branch done");
  endtask
  initial begin
    alu(16'h612f, 32'h0, 32'h8001, 1, 32'hffff8001, 1);
    alu(16'h612c, 32'h0, 32'hffffff85, 0, 32'h85, 0);
    alu(16'h612d, 32'h0, 32'hffff8085, 1, 32'h8085, 1);
    alu(16'h612b, 32'h0, 32'h1, 0, 32'hffffffff, 0);
    alu(16'h612a, 32'h0, 32'h0, 1, 32'hffffffff, 1);
    alu(16'h3128, 32'h5, 32'h7, 1, 32'hfffffffe, 1);
    alu(16'h312a, 32'h5, 32'h4, 1, 32'h0, 0);
    alu(16'h312b, 32'h80000000, 32'h1, 0, 32'h7fffffff, 1);
    alu(16'h312b, 32'h5, 32'h7, 1, 32'hfffffffe, 0);
    alu(16'h2129, 32'hff00ff00, 32'h0ff00ff0, 1, 32'h0f000f00, 1);
    alu(16'hc9f0, 32'h123456ff, 32'h0, 0, 32'hf0, 0);
    alu(16'h212b, 32'hf0, 32'h0f, 0, 32'hff, 0);
    alu(16'hcb0f, 32'hf0, 32'h0, 0, 32'hff, 0);
    alu(16'h6127, 32'h0, 32'h0f0f0f0f, 1, 32'hf0f0f0f0, 1);
    alu(16'h212a, 32'hff, 32'h0f, 0, 32'hf0, 0);
    alu(16'hca0f, 32'hff, 32'h0, 1, 32'hf0, 1);
    alu(16'h2128, 32'hf0, 32'h0f, 0, 32'hf0, 1);
    alu(16'hc810, 32'hf0, 32'h0, 1, 32'hf0, 0);
    alu(16'h4104, 32'h80000001, 32'h0, 0, 32'h3, 1);
    alu(16'h4105, 32'h80000001, 32'h0, 0, 32'hc0000000, 1);
    alu(16'h4124, 32'h40000000, 32'h0, 1, 32'h80000001, 0);
    alu(16'h4125, 32'h2, 32'h0, 1, 32'h80000001, 0);
    alu(16'h4120, 32'h80000001, 32'h0, 0, 32'h2, 1);
    alu(16'h4100, 32'h40000000, 32'h0, 1, 32'h80000000, 0);
    alu(16'h4121, 32'h80000003, 32'h0, 0, 32'hc0000001, 1);
    alu(16'h4101, 32'h80000002, 32'h0, 1, 32'h40000001, 0);
    alu(16'h4108, 32'hc0000001, 32'h0, 1, 32'h4, 1);
    alu(16'h4109, 32'h80000003, 32'h0, 0, 32'h20000000, 0);
    alu(16'h4118, 32'h12345678, 32'h0, 1, 32'h34567800, 1);
    alu(16'h4119, 32'h12345678, 32'h0, 0, 32'h123456, 0);
    alu(16'h4128, 32'h12345678, 32'h0, 1, 32'h56780000, 1);
    alu(16'h4129, 32'h12345678, 32'h0, 0, 32'h1234, 0);
    mt(16'hcd0f, 1, 0, 8'h30, 8'hf3, 8'h03, 1, 6);
    mt(16'hcf0f, 0, 1, 8'h30, 8'hf0, 8'hff, 0, 10);
    mt(16'hce0f, 1, 0, 8'h30, 8'hff, 8'hf0, 1, 6);
    mt(16'hcc0f, 0, 0, 8'h30, 8'hf0, 8'hf0, 1, 6);
    mt(16'hcc0f, 1, 1, 8'h30, 8'hf1, 8'hf1, 0, 8);
    mt(16'h411b, 0, 0, 8'h10, 8'h00, 8'h80, 1, 7);
    mt(16'h411b, 1, 1, 8'h10, 8'h05, 8'h85, 0, 11);
    t_mul();
    t_br();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire

// file: verilog/asb_alu.sv
`timescale 1ns/100ps
`default_nettype none
module asb_alu (
  // Operation
  input wire asb_pkg::asb_op_t op,
  input wire logic tIn,
  // Operands
  input wire logic [31:0] dst,
  input wire logic [31:0] src,
  // Results
  output logic [31:0] res,
  output logic tOut
);
  import asb_pkg::*;

  logic [32:0] diff;

  always_comb begin
    diff = {1'b0, dst} - {1'b0, src} - {32'h0, tIn};
    res = dst;
    tOut = tIn;
    case (op)
      OP_SEXT_HALF: res = {{16{src[15]}}, src[15:0]};
      OP_ZEXT_BYTE: res = {24'h0, src[7:0]};
      OP_ZEXT_HALF: res = {16'h0, src[15:0]};
      OP_NEGATE: res = 32'h0 - src;
      OP_NEGATE_B: begin
        diff = 33'h0 - {1'b0, src} - {32'h0, tIn};
        res = diff[31:0];
        tOut = diff[32];
      end
      OP_SUBTRACT: res = dst - src;
      OP_SUB_B: begin
        res = diff[31:0];
        tOut = diff[32];
      end
      OP_SUB_CHK: begin
        res = dst - src;
        tOut = (dst[31] != src[31]) && (res[31] != dst[31]);
      end
      OP_AND_R, OP_AND_I, OP_AND_M: res = dst & src;
      OP_OR_R, OP_OR_I, OP_OR_M: res = dst | src;
      OP_XOR_R, OP_XOR_I, OP_XOR_M: res = dst ^ src;
      OP_NOT_R: res = ~src;
      OP_TEST_R, OP_TEST_I, OP_TEST_M: tOut = (dst & src) == 32'h0;
      OP_TAS: begin
        tOut = dst[7:0] == 8'h0;
        res = {24'h0, dst[7:0] | TAS_MARK};
      end
      OP_ROT_L: begin
        res = {dst[30:0], dst[31]};
        tOut = dst[31];
      end
      OP_ROT_R: begin
        res = {dst[0], dst[31:1]};
        tOut = dst[0];
      end
      OP_ROTF_L: begin
        res = {dst[30:0], tIn};
        tOut = dst[31];
      end
      OP_ROTF_R: begin
        res = {tIn, dst[31:1]};
        tOut = dst[0];
      end
      OP_SHL1: begin
        res = {dst[30:0], 1'b0};
        tOut = dst[31];
      end
      OP_SAR1: begin
        res = {dst[31], dst[31:1]};
        tOut = dst[0];
      end
      OP_SHR1: begin
        res = {1'b0, dst[31:1]};
        tOut = dst[0];
      end
      OP_SHL2: res = {dst[29:0], 2'h0};
      OP_SHR2: res = {2'h0, dst[31:2]};
      OP_SHL8: res = {dst[23:0], 8'h0};
      OP_SHR8: res = {8'h0, dst[31:8]};
      OP_SHL16: res = {dst[15:0], 16'h0};
      OP_SHR16: res = {16'h0, dst[31:16]};
      default: res = dst;
    endcase
  end

endmodule
`default_nettype wire

// file: verilog/asb_core.sv
// Behaviour
// - Sign-extend low half of source into destination, one cycle, flag unchanged.
// - Zero-extend low byte or low half of source into destination, one cycle.
// - Multiply two signed memory halves, add into accumulator, post-increment both pointers.
// - Signed and unsigned register multiplies place product in accumulator.
// - Negate source; negate-with-borrow also subtracts flag and stores borrow.
// - Subtract source from destination; borrow form also subtracts flag, stores borrow.
// - Signed subtract sets flag on overflow of the result, else clears it.
// - AND register pair, or zero-extended immediate into register zero; flag unchanged.
// - Byte AND/OR/XOR at register zero plus global base, read-modify-write, 3 cycles.
// - OR source into destination; complement source into destination; one cycle.
// - XOR source into destination, or immediate into register zero, one cycle.
// - AND without storing; flag set when result zero, register or immediate form.
// - Test memory byte at register zero plus global base, no write, 3 cycles.
// - Rotate left or right one bit, outgoing bit wraps and goes to flag.
// - Rotate left or right through the flag.
// - Shift left one with zero fill, outgoing top bit into flag.
// - Shift by two, eight or sixteen with zero fill, flag unchanged.
// - Delayed relative jump and call in 2 cycles; call saves return address.
// - Delayed register jump, register call and return, 2 cycles each.
`timescale 1ns/100ps
`default_nettype none
module asb_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Instruction fetch
  output var asb_pkg::asb_fetch_t fetch,
  input wire logic fetchValid,
  input wire logic [15:0] fetchData,
  // Data memory
  output var asb_pkg::asb_mem_req_t mem,
  input wire logic memValid,
  input wire logic [31:0] memRdata,
  // Register access from the rest of the core
  input wire logic regWrEn,
  input wire logic [3:0] regWrIdx,
  input wire logic [31:0] regWrData,
  input wire logic [3:0] regRdIdx,
  output logic [31:0] regRdData,
  input wire logic [31:0] globalBase,
  // Status
  output logic tFlag,
  output logic [31:0] pcValue,
  output logic [63:0] accValue,
  output logic [31:0] procRetValue
);
  import asb_pkg::*;

  asb_core_t s;
  asb_core_t next_s;
  asb_op_t op;
  logic [3:0] dIdx;
  logic [3:0] sIdx;
  logic [31:0] dstVal;
  logic [31:0] srcVal;
  logic [31:0] immZ;
  logic immForm;
  logic memForm;
  logic [31:0] aluDst;
  logic [31:0] aluSrc;
  logic [31:0] aluRes;
  logic aluT;
  logic [31:0] mulA;
  logic [31:0] mulB;
  logic [63:0] mulAcc;
  logic done;

  always_comb begin
    op = asb_decode(s.ir);
    dIdx = s.ir[11:8];
    sIdx = s.ir[7:4];
    dstVal = s.regs[dIdx];
    srcVal = s.regs[sIdx];
    immZ = {24'h0, s.ir[7:0]};
    immForm = op inside {OP_AND_I, OP_OR_I, OP_XOR_I, OP_TEST_I};
    memForm = op inside {OP_AND_M, OP_OR_M, OP_XOR_M, OP_TEST_M, OP_TAS};
    // Memory forms feed the read bus byte to the ALU in every state; only the read completion keeps the result.
    aluDst = memForm ? {24'h0, memRdata[7:0]} : (immForm ? s.regs[0] : dstVal);
    aluSrc = (immForm || memForm) ? immZ : srcVal;
    mulA = (s.st == ST_MRD2) ? s.memData : dstVal;
    mulB = (s.st == ST_MRD2) ? memRdata : srcVal;
  end

  asb_alu u_alu (
    .op(op),
    .tIn(s.tFlag),
    .dst(aluDst),
    .src(aluSrc),
    .res(aluRes),
    .tOut(aluT)
  );

  asb_mul u_mul (
    .op(op),
    .a(mulA),
    .b(mulB),
    .accIn(s.acc),
    .accOut(mulAcc)
  );

  always_comb begin
    next_s = s;
    done = 1'b0;
    fetch = '0;
    mem = '0;
    case (s.st)
      ST_FETCH: begin
        fetch.req = ce;
        fetch.addr = s.pc;
        if (regWrEn) begin
          next_s.regs[regWrIdx] = regWrData;
        end
        if (fetchValid) begin
          next_s.ir = fetchData;
          next_s.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_s.npc = s.pc + INSN_BYTES;
        done = 1'b1;
        case (op)
          OP_SEXT_HALF, OP_ZEXT_BYTE, OP_ZEXT_HALF, OP_NEGATE, OP_SUBTRACT, OP_AND_R,
          OP_OR_R, OP_XOR_R, OP_NOT_R, OP_SHL2, OP_SHR2, OP_SHL8, OP_SHR8, OP_SHL16,
          OP_SHR16: begin
            next_s.regs[dIdx] = aluRes;
          end
          OP_NEGATE_B, OP_SUB_B, OP_SUB_CHK, OP_ROT_L, OP_ROT_R, OP_ROTF_L, OP_ROTF_R,
          OP_SHL1, OP_SAR1, OP_SHR1: begin
            next_s.regs[dIdx] = aluRes;
            next_s.tFlag = aluT;
          end
          OP_AND_I, OP_OR_I, OP_XOR_I: begin
            next_s.regs[0] = aluRes;
          end
          OP_TEST_R, OP_TEST_I: begin
            next_s.tFlag = aluT;
          end
          OP_MUL_S, OP_MUL_U: begin
            next_s.acc = mulAcc;
          end
          OP_MULACC: begin
            // Both pointers step even when they name the same register.
            next_s.memAddr = dstVal;
            next_s.memAddr2 = srcVal;
            next_s.regs[dIdx] = dstVal + HALF_STEP;
            next_s.regs[sIdx] = next_s.regs[sIdx] + HALF_STEP;
            next_s.st = ST_MRD;
            done = 1'b0;
          end
          OP_AND_M, OP_OR_M, OP_XOR_M, OP_TEST_M: begin
            next_s.memAddr = s.regs[0] + globalBase;
            next_s.st = ST_MRD;
            done = 1'b0;
          end
          OP_TAS: begin
            next_s.memAddr = dstVal;
            next_s.st = ST_MRD;
            done = 1'b0;
          end
          OP_BR_CLR, OP_BR_SET: begin
            if (s.tFlag == (op == OP_BR_SET)) begin
              next_s.npc = s.pc + PC_AHEAD + dispShort(s.ir);
              next_s.stall = STALL_TAKEN;
              next_s.st = ST_STALL;
              done = 1'b0;
            end
          end
          OP_BR_REL, OP_CALL_REL, OP_BR_REG, OP_CALL_REG, OP_RETURN: begin
            next_s.delayPend = 1'b1;
            next_s.armed = 1'b1;
            next_s.stall = STALL_DELAYED;
            next_s.st = ST_STALL;
            done = 1'b0;
            if (op == OP_CALL_REL || op == OP_CALL_REG) begin
              next_s.procRet = s.pc + PC_AHEAD;
            end
            if (op == OP_BR_REL || op == OP_CALL_REL) begin
              next_s.delayTgt = s.pc + PC_AHEAD + dispLong(s.ir);
            end else if (op == OP_RETURN) begin
              next_s.delayTgt = s.procRet;
            end else begin
              next_s.delayTgt = dstVal;
            end
          end
          default: begin
            done = 1'b1;
          end
        endcase
      end
      ST_MRD: begin
        mem.req = ce;
        mem.size = (op == OP_MULACC) ? SIZE_HALF : SIZE_BYTE;
        mem.addr = s.memAddr;
        if (memValid) begin
          next_s.memData = (op == OP_MULACC) ? memRdata : aluRes;
          if (op == OP_MULACC) begin
            next_s.st = ST_MRD2;
          end else if (op == OP_TEST_M) begin
            next_s.tFlag = aluT;
            next_s.stall = STALL_TEST_MEM;
            next_s.st = ST_STALL;
          end else begin
            if (op == OP_TAS) begin
              next_s.tFlag = aluT;
            end
            next_s.st = ST_MWR;
          end
        end
      end
      ST_MRD2: begin
        mem.req = ce;
        mem.size = SIZE_HALF;
        mem.addr = s.memAddr2;
        if (memValid) begin
          next_s.acc = mulAcc;
          done = 1'b1;
        end
      end
      ST_MWR: begin
        mem.req = ce;
        mem.write = 1'b1;
        mem.size = SIZE_BYTE;
        mem.addr = s.memAddr;
        mem.wdata = {24'h0, s.memData[7:0]};
        if (memValid) begin
          if (op == OP_TAS) begin
            next_s.stall = STALL_TAS;
            next_s.st = ST_STALL;
          end else begin
            done = 1'b1;
          end
        end
      end
      ST_STALL: begin
        if (s.stall == 2'h0) begin
          done = 1'b1;
        end else begin
          next_s.stall = s.stall - 2'h1;
        end
      end
      default: begin
        next_s.st = ST_FETCH;
      end
    endcase
    // A pending target is taken only once the slot instruction has finished.
    if (done) begin
      next_s.st = ST_FETCH;
      next_s.armed = 1'b0;
      if (s.delayPend && !s.armed) begin
        next_s.pc = s.delayTgt;
        next_s.delayPend = 1'b0;
      end else begin
        next_s.pc = next_s.npc;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= CORE_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign regRdData = s.regs[regRdIdx];
  assign tFlag = s.tFlag;
  assign pcValue = s.pc;
  assign accValue = s.acc;
  assign procRetValue = s.procRet;

  // Checking helpers.
  logic ex;
  logic [31:0] subRaw;
  logic subOvf;
  logic testZero;
  logic dstTop;
  logic [31:0] dispB;
  assign ex = s.st == ST_EXEC;
  assign subRaw = dstVal - srcVal;
  assign subOvf = (dstVal[31] ^ srcVal[31]) & (dstVal[31] ^ subRaw[31]);
  assign testZero = (dstVal & srcVal) == 32'h0;
  assign dstTop = dstVal[31];
  assign dispB = dispShort(s.ir);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !ce);

  property p_sext;
    ex && op == OP_SEXT_HALF |=>
      ((s.regs[$past(dIdx)] ^ $past(srcVal)) & 32'h0000_ffff) == 32'h0 &&
      s.regs[$past(dIdx)][31:16] == {16{s.regs[$past(dIdx)][15]}} &&
      s.tFlag == $past(s.tFlag);
  endproperty
  a_sext: assert property (p_sext) else $error("sign extend wrong");

  property p_zext;
    ex && op == OP_ZEXT_BYTE |=> s.regs[$past(dIdx)] == ($past(srcVal) & 32'h0000_00ff);
  endproperty
  a_zext: assert property (p_zext) else $error("zero extend wrong");

  property p_negate;
    ex && op == OP_NEGATE |=> s.regs[$past(dIdx)] == 32'h0 - $past(srcVal);
  endproperty
  a_negate: assert property (p_negate) else $error("negate wrong");

  property p_sub_chk;
    ex && op == OP_SUB_CHK |=> s.tFlag == $past(subOvf);
  endproperty
  a_sub_chk: assert property (p_sub_chk) else $error("underflow flag wrong");

  property p_test;
    ex && op == OP_TEST_R |=> s.tFlag == $past(testZero) && s.regs == $past(s.regs);
  endproperty
  a_test: assert property (p_test) else $error("test flag wrong");

  property p_shl;
    ex && op == OP_SHL1 |=>
      s.tFlag == $past(dstTop) && s.regs[$past(dIdx)] == ($past(dstVal) << 1);
  endproperty
  a_shl: assert property (p_shl) else $error("shift left wrong");

  property p_taken;
    ex && op == OP_BR_SET && s.tFlag |=> s.st == ST_STALL ##1 s.st == ST_STALL ##1
      (s.st == ST_FETCH && s.pc == $past(s.pc, 3) + 32'h4 + $past(dispB, 3));
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch timing wrong");

  property p_slot;
    ex && op == OP_BR_REL |=> s.st == ST_STALL ##1
      (s.st == ST_FETCH && fetch.addr == $past(s.pc, 2) + 32'h2);
  endproperty
  a_slot: assert property (p_slot) else $error("delay slot skipped");

  property p_call;
    ex && op == OP_CALL_REL |=> s.procRet == $past(s.pc) + 32'h4;
  endproperty
  a_call: assert property (p_call) else $error("return address wrong");

  property p_mulhi;
    ex && op == OP_MUL_U |=> (s.acc >> 32) == ($past(s.acc) >> 32);
  endproperty
  a_mulhi: assert property (p_mulhi) else $error("upper accumulator disturbed");

  property p_cov_mulacc;
    ex && op == OP_MULACC ##[1:20] s.st == ST_FETCH;
  endproperty
  c_cov_mulacc: cover property (p_cov_mulacc);

  property p_cov_tas;
    s.st == ST_MWR && op == OP_TAS && memValid;
  endproperty
  c_cov_tas: cover property (p_cov_tas);

  property p_cov_delay;
    s.delayPend && !s.armed && done;
  endproperty
  c_cov_delay: cover property (p_cov_delay);

endmodule
`default_nettype wire

// file: verilog/asb_mul.sv
`timescale 1ns/100ps
`default_nettype none
module asb_mul (
  // Operation and operands
  input wire asb_pkg::asb_op_t op,
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // Accumulator
  input wire logic [63:0] accIn,
  output logic [63:0] accOut
);
  import asb_pkg::*;

  logic signed [31:0] sProd;
  logic [31:0] uProd;

  // Operands are the low halves, so the product always fits 32 bits.
  always_comb begin
    sProd = $signed(a[15:0]) * $signed(b[15:0]);
    uProd = {16'h0, a[15:0]} * {16'h0, b[15:0]};
    case (op)
      OP_MUL_S: accOut = {accIn[63:32], sProd};
      OP_MUL_U: accOut = {accIn[63:32], uProd};
      OP_MULACC: accOut = accIn + {{32{sProd[31]}}, sProd};
      default: accOut = accIn;
    endcase
  end

endmodule
`default_nettype wire

// file: verilog/asb_pkg.sv
package asb_pkg;

  typedef enum logic [5:0] {
    OP_NONE, OP_SEXT_HALF, OP_ZEXT_BYTE, OP_ZEXT_HALF, OP_MULACC, OP_MUL_S, OP_MUL_U,
    OP_NEGATE, OP_NEGATE_B, OP_SUBTRACT, OP_SUB_B, OP_SUB_CHK,
    OP_AND_R, OP_AND_I, OP_AND_M, OP_NOT_R, OP_OR_R, OP_OR_I, OP_OR_M,
    OP_XOR_R, OP_XOR_I, OP_XOR_M, OP_TEST_R, OP_TEST_I, OP_TEST_M, OP_TAS,
    OP_ROT_L, OP_ROT_R, OP_ROTF_L, OP_ROTF_R, OP_SHL1, OP_SAR1, OP_SHR1,
    OP_SHL2, OP_SHR2, OP_SHL8, OP_SHR8, OP_SHL16, OP_SHR16,
    OP_BR_CLR, OP_BR_SET, OP_BR_REL, OP_CALL_REL, OP_BR_REG, OP_CALL_REG, OP_RETURN
  } asb_op_t;

  typedef enum logic [2:0] {ST_FETCH, ST_EXEC, ST_MRD, ST_MRD2, ST_MWR, ST_STALL} asb_state_t;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] STALL_TAKEN = 2'h1;
  localparam logic [1:0] STALL_DELAYED = 2'h0;
  localparam logic [1:0] STALL_TEST_MEM = 2'h0;
  localparam logic [1:0] STALL_TAS = 2'h0;
  localparam logic [31:0] RESET_PC = 32'h0;
  localparam logic [31:0] PC_AHEAD = 32'h4;
  localparam logic [31:0] INSN_BYTES = 32'h2;
  localparam logic [31:0] HALF_STEP = 32'h2;
  localparam logic [7:0] TAS_MARK = 8'h80;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } asb_fetch_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } asb_mem_req_t;

  typedef struct packed {
    asb_state_t st;
    logic [31:0] pc;
    logic [31:0] npc;
    logic [31:0] procRet;
    logic tFlag;
    logic [63:0] acc;
    logic [15:0] ir;
    logic [1:0] stall;
    logic [31:0] memAddr;
    logic [31:0] memAddr2;
    logic [31:0] memData;
    logic delayPend;
    logic armed;
    logic [31:0] delayTgt;
    logic [15:0][31:0] regs;
  } asb_core_t;

  localparam asb_core_t CORE_RESET = '0;

  function automatic logic [31:0] dispShort(input logic [15:0] ir);
    dispShort = {{23{ir[7]}}, ir[7:0], 1'b0};
  endfunction

  function automatic logic [31:0] dispLong(input logic [15:0] ir);
    dispLong = {{19{ir[11]}}, ir[11:0], 1'b0};
  endfunction

  function automatic asb_op_t asb_decode(input logic [15:0] ir);
    casez (ir)
      16'h6??f: asb_decode = OP_SEXT_HALF;
      16'h6??c: asb_decode = OP_ZEXT_BYTE;
      16'h6??d: asb_decode = OP_ZEXT_HALF;
      16'h6??b: asb_decode = OP_NEGATE;
      16'h6??a: asb_decode = OP_NEGATE_B;
      16'h6??7: asb_decode = OP_NOT_R;
      16'h4??f: asb_decode = OP_MULACC;
      16'h2??f: asb_decode = OP_MUL_S;
      16'h2??e: asb_decode = OP_MUL_U;
      16'h2??9: asb_decode = OP_AND_R;
      16'h2??b: asb_decode = OP_OR_R;
      16'h2??a: asb_decode = OP_XOR_R;
      16'h2??8: asb_decode = OP_TEST_R;
      16'h3??8: asb_decode = OP_SUBTRACT;
      16'h3??a: asb_decode = OP_SUB_B;
      16'h3??b: asb_decode = OP_SUB_CHK;
      16'hc9??: asb_decode = OP_AND_I;
      16'hcb??: asb_decode = OP_OR_I;
      16'hca??: asb_decode = OP_XOR_I;
      16'hc8??: asb_decode = OP_TEST_I;
      16'hcd??: asb_decode = OP_AND_M;
      16'hcf??: asb_decode = OP_OR_M;
      16'hce??: asb_decode = OP_XOR_M;
      16'hcc??: asb_decode = OP_TEST_M;
      16'h4?1b: asb_decode = OP_TAS;
      16'h4?04: asb_decode = OP_ROT_L;
      16'h4?05: asb_decode = OP_ROT_R;
      16'h4?24: asb_decode = OP_ROTF_L;
      16'h4?25: asb_decode = OP_ROTF_R;
      16'h4?20, 16'h4?00: asb_decode = OP_SHL1;
      16'h4?21: asb_decode = OP_SAR1;
      16'h4?01: asb_decode = OP_SHR1;
      16'h4?08: asb_decode = OP_SHL2;
      16'h4?09: asb_decode = OP_SHR2;
      16'h4?18: asb_decode = OP_SHL8;
      16'h4?19: asb_decode = OP_SHR8;
      16'h4?28: asb_decode = OP_SHL16;
      16'h4?29: asb_decode = OP_SHR16;
      16'h4?2b: asb_decode = OP_BR_REG;
      16'h4?0b: asb_decode = OP_CALL_REG;
      16'h8b??: asb_decode = OP_BR_CLR;
      16'h89??: asb_decode = OP_BR_SET;
      16'ha???: asb_decode = OP_BR_REL;
      16'hb???: asb_decode = OP_CALL_REL;
      16'h000b: asb_decode = OP_RETURN;
      default: asb_decode = OP_NONE;
    endcase
  endfunction

endpackage
